//--- hw/hdlc_status_pkg.sv
// constants for the hdlc channel status and second control register block
// assumes an 8-bit host register port and one 40 MHz system clock
package hdlc_status_pkg;

   // ==========================================================
   // register addresses on the host port
   localparam logic [4:0] ADDR_FIFO_DATA  = 5'h12;
   localparam logic [4:0] ADDR_STATUS     = 5'h14;
   localparam logic [4:0] ADDR_CONTROL2   = 5'h15;
   localparam logic [4:0] ADDR_INT_STATUS = 5'h17;

   // ==========================================================
   // second control register fields
   localparam int          CTL_INT_SELECT    = 7;
   localparam int          CTL_COUNT_RELOAD  = 6;
   localparam int          CTL_CHECK_SUPPRESS = 5;
   localparam int          CTL_SHORT_ADDRESS = 4;
   localparam int          CTL_RX_FLUSH      = 1;
   localparam int          CTL_TX_FLUSH      = 0;
   localparam logic [7:0]  CONTROL2_RESET    = 8'h00;

   // ==========================================================
   // status register fields
   localparam int          STS_INT_RAISED = 7;
   localparam int          STS_IDLE       = 6;
   localparam int          STS_TAG_LSB    = 4;
   localparam int          STS_TX_LSB     = 2;
   localparam int          STS_RX_LSB     = 0;

   // ==========================================================
   // byte tags and fill codes
   localparam logic [1:0]  TAG_PACKET    = 2'h0;
   localparam logic [1:0]  TAG_FIRST     = 2'h1;
   localparam logic [1:0]  TAG_LAST_GOOD = 2'h2;
   localparam logic [1:0]  TAG_LAST_BAD  = 2'h3;
   localparam logic [1:0]  TX_AT_LEVEL   = 2'h0;
   localparam logic [1:0]  TX_AT_THRESH  = 2'h1;
   localparam logic [1:0]  TX_EMPTY      = 2'h2;
   localparam logic [1:0]  TX_BELOW      = 2'h3;
   localparam logic [1:0]  RX_EMPTY      = 2'h0;
   localparam logic [1:0]  RX_BELOW      = 2'h1;
   localparam logic [1:0]  RX_FULL       = 2'h2;
   localparam logic [1:0]  RX_AT_THRESH  = 2'h3;

   // ==========================================================
   // line patterns, queue sizes and synchroniser slots
   localparam logic [7:0]  FLAG_PATTERN   = 8'h7e;
   localparam logic [3:0]  IDLE_ONES      = 4'hf;
   localparam logic [3:0]  ABORT_ONES     = 4'h7;
   localparam logic [4:0]  ABORT_MIN_BITS = 5'h1a;
   localparam int          RX_DEPTH       = 128;
   localparam int          TX_DEPTH       = 128;
   localparam int          SYNC_CS        = 0;
   localparam int          SYNC_RD        = 1;
   localparam int          SYNC_WR        = 2;
   localparam int          SYNC_LCLK      = 3;
   localparam int          SYNC_LDATA     = 4;
   localparam logic [4:0]  SYNC_RESET     = 5'h07;

endpackage

//--- hw/hdlc_byte_queue.sv
// byte queue with tag bits, used for both receive and transmit sides
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
module hdlc_byte_queue
#(
   parameter int WIDTH   = 10,
   parameter int DEPTH   = 128,
   parameter int COUNT_W = 8
)
(
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic               flush,
   input  wire logic               push,
   input  wire logic [WIDTH-1:0]   push_data,
   input  wire logic               pop,
   output logic      [WIDTH-1:0]   head_data,
   output logic      [COUNT_W-1:0] count,
   output logic                    empty,
   output logic                    full
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [PW-1:0]      rd;
      logic [PW-1:0]      wr;
      logic [COUNT_W-1:0] count;
   } queue_t;

   queue_t           q;
   queue_t           d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push_ok;
   logic             pop_ok;

   function automatic logic [PW-1:0] advance(input logic [PW-1:0] p);
      advance = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // flags and accepted moves
   assign empty     = (q.count == '0);
   assign full      = (q.count == COUNT_W'(DEPTH));
   assign count     = q.count;
   assign head_data = mem[q.rd];
   assign push_ok   = push & ~full & ~flush;
   assign pop_ok    = pop & ~empty & ~flush;

   // pointer update; a flush only touches pointers and count
   always_comb
   begin
      d = q;
      if (flush)
      begin
         d = '0;
      end
      else
      begin
         if (push_ok)
            d.wr = advance(q.wr);
         if (pop_ok)
            d.rd = advance(q.rd);
         if (push_ok && !pop_ok)
            d.count = q.count + 1'b1;
         else if (pop_ok && !push_ok)
            d.count = q.count - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         q <= '0;
      else
         q <= d;
   end

   always_ff @(posedge clk)
   begin
      if (push_ok)
         mem[q.wr] <= push_data;
   end

   flush_empty_a: assert property (@(posedge clk) disable iff (!reset_n)
      flush |=> empty)
      else $error("queue not empty after flush");

endmodule

//--- hw/hdlc_line_watch.sv
// watches the received bit stream for flags, aborts and idle channel
// assumes bit_strobe is a one-cycle pulse from synchronised line pins
`timescale 1ns/1ps
module hdlc_line_watch
(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic bit_strobe,
   input  wire logic bit_value,
   output logic      idle_channel,
   output logic      flag_seen,
   output logic      abort_seen
);
   typedef struct packed {
      logic [7:0] shift;
      logic [3:0] ones;
      logic [4:0] bits;
      logic       in_frame;
      logic       idle;
      logic       flag;
      logic       abort;
   } watch_t;

   watch_t q;
   watch_t d;
   logic [7:0] shift_next;

   assign shift_next   = {q.shift[6:0], bit_value};
   assign idle_channel = q.idle;
   assign flag_seen    = q.flag;
   assign abort_seen   = q.abort;

   // pattern tracking per received bit
   always_comb
   begin
      d       = q;
      d.flag  = 1'b0;
      d.abort = 1'b0;
      if (bit_strobe)
      begin
         d.shift = shift_next;
         if (q.bits != hdlc_status_pkg::ABORT_MIN_BITS)
            d.bits = q.bits + 1'b1;
         if (bit_value)
         begin
            if (q.ones != hdlc_status_pkg::IDLE_ONES)
               d.ones = q.ones + 1'b1;
            if (q.ones == hdlc_status_pkg::IDLE_ONES - 4'h1)
               d.idle = 1'b1;
            if (q.ones == hdlc_status_pkg::ABORT_ONES - 4'h1 && q.in_frame)
            begin
               d.abort    = (q.bits >= hdlc_status_pkg::ABORT_MIN_BITS - 5'h1);
               d.in_frame = 1'b0;
            end
         end
         else
         begin
            d.ones = 4'h0;
            d.idle = 1'b0;
         end
         if (shift_next == hdlc_status_pkg::FLAG_PATTERN)
         begin
            d.flag     = 1'b1;
            d.in_frame = 1'b1;
            d.bits     = 5'h0;
         end
      end
   end

   // idle reads one from reset until a zero arrives
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         q      <= '0;
         q.idle <= 1'b1;
      end
      else
         q <= d;
   end

   idle_set_a: assert property (@(posedge clk) disable iff (!reset_n)
      (bit_strobe && bit_value && q.ones == 4'he) |=> idle_channel)
      else $error("idle not set after fifteen ones");

   idle_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      (bit_strobe && !bit_value) |=> !idle_channel)
      else $error("idle still set after a zero");

   abort_min_a: assert property (@(posedge clk) disable iff (!reset_n)
      abort_seen |-> $past(q.bits) >= hdlc_status_pkg::ABORT_MIN_BITS - 5'h1)
      else $error("abort flagged too early in frame");

endmodule

//--- hw/hdlc_status_control.sv
// hdlc channel status register, second control register and queues
// assumes async host strobes and line pins; everything else on clk
// Overview of operation
// - interrupt bit sets on event, clears on interrupt status read
// - fifteen ones in a row flag idle
// - idle reads one after reset until valid
// - two-bit tag of next receive byte
// - transmit queue fill state code
// - receive queue fill state code
// - select underrun or abort for bit two
// - byte counter reloads first value minus one
// - suppress check sequence after end tag
// - short mode compares seven address bits
// - short address needs bit zero set
// - receive flush empties queue, stops receiver
// - receive flush keeps stored data
// - transmit flush empties, clears on write
// - transmit flush keeps stored data
// - fetch from empty queue flags underrun
// - abort counts only after enough bits
// - full receive queue overflows, stops receiver
`timescale 1ns/1ps
module hdlc_status_control
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic [4:0] host_addr,
   input  wire logic [7:0] host_data_in,
   output logic      [7:0] host_data_out,
   output logic            host_data_oe_n,
   input  wire logic       host_cs_n,
   input  wire logic       host_rd_n,
   input  wire logic       host_wr_n,
   input  wire logic       receive_line_clock,
   input  wire logic       rx_line_data,
   input  wire logic       rx_write_valid,
   input  wire logic [7:0] rx_write_data,
   input  wire logic [1:0] rx_write_tag,
   input  wire logic [7:0] rx_threshold,
   input  wire logic [7:0] tx_threshold,
   input  wire logic [7:0] tx_full_level,
   input  wire logic       packet_end_tag,
   input  wire logic       frame_abort_flag,
   input  wire logic       tx_fetch,
   output logic      [7:0] tx_byte,
   output logic      [1:0] tx_byte_tag,
   output logic            tx_append_check,
   output logic            tx_underrun_flag,
   input  wire logic       tx_count_load,
   input  wire logic [7:0] tx_count_value,
   output logic      [7:0] tx_count,
   input  wire logic       rx_address_valid,
   input  wire logic [7:0] rx_address_byte,
   input  wire logic [7:0] own_address,
   output logic            address_match,
   input  wire logic       unmasked_event,
   output logic            interrupt_bit2_event,
   output logic            rx_abort_event,
   output logic            rx_overflow_flag,
   output logic            rx_enabled
);
   typedef struct packed {
      logic [4:0] sync_m;
      logic [4:0] sync_s;
      logic [4:0] sync_p;
      logic [4:0] addr_m;
      logic [4:0] addr_s;
      logic [7:0] data_m;
      logic [7:0] data_s;
      logic [7:0] control;
      logic       int_raised;
      logic [7:0] rdata;
      logic       oe_n;
      logic [7:0] tx_byte;
      logic [1:0] tx_tag;
      logic       append_check;
      logic       underrun;
      logic [7:0] count;
      logic [7:0] count_first;
      logic       addr_match;
      logic       bit2_event;
      logic       abort;
      logic       overflow;
      logic       rx_on;
   } state_t;

   state_t q;
   state_t d;

   // ==========================================================
   // host strobe decode
   logic       rd_edge;
   logic       wr_edge;
   logic       line_strobe;
   logic       idle_channel;
   logic       flag_seen;
   logic       abort_seen;
   logic       rx_flush;
   logic       tx_flush;
   logic       rx_push;
   logic       rx_pop;
   logic       tx_push;
   logic       tx_pop;
   logic [9:0] rx_head;
   logic [9:0] tx_head;
   logic [7:0] rx_count;
   logic [7:0] tx_level;
   logic       rx_empty;
   logic       rx_full;
   logic       tx_empty;
   logic       tx_full;
   logic [7:0] status_value;

   function automatic logic fell(input state_t s, input int slot);
      fell = s.sync_p[slot] & ~s.sync_s[slot];
   endfunction

   function automatic logic hit(input state_t s, input logic [4:0] a);
      hit = ~s.sync_s[hdlc_status_pkg::SYNC_CS] & (s.addr_s == a);
   endfunction

   // access pulses on falling strobe edges while selected
   assign rd_edge     = fell(q, hdlc_status_pkg::SYNC_RD) & ~q.sync_s[hdlc_status_pkg::SYNC_CS];
   assign wr_edge     = fell(q, hdlc_status_pkg::SYNC_WR) & ~q.sync_s[hdlc_status_pkg::SYNC_CS];
   assign line_strobe = q.sync_s[hdlc_status_pkg::SYNC_LCLK]
                        & ~q.sync_p[hdlc_status_pkg::SYNC_LCLK];

   // ==========================================================
   // queue control
   // flush held while bit is high
   assign rx_flush = q.control[hdlc_status_pkg::CTL_RX_FLUSH];
   assign tx_push  = wr_edge & hit(q, hdlc_status_pkg::ADDR_FIFO_DATA);
   // the clearing write itself is stored
   assign tx_flush = q.control[hdlc_status_pkg::CTL_TX_FLUSH] & ~tx_push;
   assign rx_push  = rx_write_valid & q.rx_on & ~rx_flush;
   assign rx_pop   = rd_edge & hit(q, hdlc_status_pkg::ADDR_FIFO_DATA);
   assign tx_pop   = tx_fetch;

   // receive queue, flush resets pointers and count only
   hdlc_byte_queue
   #(
      .WIDTH   (10),
      .DEPTH   (hdlc_status_pkg::RX_DEPTH),
      .COUNT_W (8)
   )
   rx_queue
   (
      .clk       (clk),
      .reset_n   (reset_n),
      .flush     (rx_flush),
      .push      (rx_push),
      .push_data ({rx_write_tag, rx_write_data}),
      .pop       (rx_pop),
      .head_data (rx_head),
      .count     (rx_count),
      .empty     (rx_empty),
      .full      (rx_full)
   );

   // transmit queue, flush resets pointers and count only
   hdlc_byte_queue
   #(
      .WIDTH   (10),
      .DEPTH   (hdlc_status_pkg::TX_DEPTH),
      .COUNT_W (8)
   )
   tx_queue
   (
      .clk       (clk),
      .reset_n   (reset_n),
      .flush     (tx_flush),
      .push      (tx_push),
      .push_data ({packet_end_tag, frame_abort_flag, q.data_s}),
      .pop       (tx_pop),
      .head_data (tx_head),
      .count     (tx_level),
      .empty     (tx_empty),
      .full      (tx_full)
   );

   hdlc_line_watch line_watch
   (
      .clk          (clk),
      .reset_n      (reset_n),
      .bit_strobe   (line_strobe),
      .bit_value    (q.sync_s[hdlc_status_pkg::SYNC_LDATA]),
      .idle_channel (idle_channel),
      .flag_seen    (flag_seen),
      .abort_seen   (abort_seen)
   );

   // ==========================================================
   // status register image
   always_comb
   begin
      status_value = 8'h00;
      status_value[hdlc_status_pkg::STS_INT_RAISED] = q.int_raised;
      status_value[hdlc_status_pkg::STS_IDLE] = idle_channel;
      // tag of next byte to read
      status_value[hdlc_status_pkg::STS_TAG_LSB +: 2] = rx_head[9:8];
      if (tx_empty)
         status_value[hdlc_status_pkg::STS_TX_LSB +: 2] = hdlc_status_pkg::TX_EMPTY;
      else if (tx_level >= tx_full_level)
         status_value[hdlc_status_pkg::STS_TX_LSB +: 2] = hdlc_status_pkg::TX_AT_LEVEL;
      else if (tx_level >= tx_threshold)
         status_value[hdlc_status_pkg::STS_TX_LSB +: 2] = hdlc_status_pkg::TX_AT_THRESH;
      else
         status_value[hdlc_status_pkg::STS_TX_LSB +: 2] = hdlc_status_pkg::TX_BELOW;
      if (rx_empty)
         status_value[hdlc_status_pkg::STS_RX_LSB +: 2] = hdlc_status_pkg::RX_EMPTY;
      else if (rx_full)
         status_value[hdlc_status_pkg::STS_RX_LSB +: 2] = hdlc_status_pkg::RX_FULL;
      else if (rx_count >= rx_threshold)
         status_value[hdlc_status_pkg::STS_RX_LSB +: 2] = hdlc_status_pkg::RX_AT_THRESH;
      else
         status_value[hdlc_status_pkg::STS_RX_LSB +: 2] = hdlc_status_pkg::RX_BELOW;
   end

   // ==========================================================
   // next state
   always_comb
   begin
      d        = q;
      d.sync_m = {rx_line_data, receive_line_clock, host_wr_n, host_rd_n, host_cs_n};
      d.sync_s = q.sync_m;
      d.sync_p = q.sync_s;
      d.addr_m = host_addr;
      d.addr_s = q.addr_m;
      d.data_m = host_data_in;
      d.data_s = q.data_m;
      d.oe_n   = q.sync_s[hdlc_status_pkg::SYNC_CS] | q.sync_s[hdlc_status_pkg::SYNC_RD];
      // only the control register and the transmit queue take writes
      if (wr_edge && hit(q, hdlc_status_pkg::ADDR_CONTROL2))
         d.control = q.data_s;
      // write to transmit queue ends flush
      if (tx_push)
         d.control[hdlc_status_pkg::CTL_TX_FLUSH] = 1'b0;
      if (rd_edge)
      begin
         unique case (q.addr_s)
            hdlc_status_pkg::ADDR_STATUS:    d.rdata = status_value;
            hdlc_status_pkg::ADDR_CONTROL2:  d.rdata = q.control;
            hdlc_status_pkg::ADDR_FIFO_DATA: d.rdata = rx_head[7:0];
            default:                         d.rdata = 8'h00;
         endcase
      end
      // event wins over the clearing read
      d.int_raised = unmasked_event
                     | (q.int_raised & ~(rd_edge & hit(q, hdlc_status_pkg::ADDR_INT_STATUS)));
      d.underrun = tx_pop & tx_empty;
      if (tx_pop && !tx_empty)
      begin
         d.tx_byte = tx_head[7:0];
         d.tx_tag  = tx_head[9:8];
         // check sequence only when not suppressed
         d.append_check = tx_head[9] & ~q.control[hdlc_status_pkg::CTL_CHECK_SUPPRESS];
         // reload with first value minus one
         if (q.count == 8'h01 && q.control[hdlc_status_pkg::CTL_COUNT_RELOAD])
            d.count = q.count_first - 8'h01;
         else if (q.count != 8'h00)
            d.count = q.count - 8'h01;
      end
      if (tx_count_load)
      begin
         d.count       = tx_count_value;
         d.count_first = tx_count_value;
      end
      if (rx_address_valid)
      begin
         if (q.control[hdlc_status_pkg::CTL_SHORT_ADDRESS])
            d.addr_match = rx_address_byte[0] & (rx_address_byte[7:1] == own_address[7:1]);
         else
            d.addr_match = (rx_address_byte == own_address);
      end
      d.abort = abort_seen;
      d.bit2_event = q.control[hdlc_status_pkg::CTL_INT_SELECT] ? d.underrun : abort_seen;
      // overflow stops receiver until next flag
      d.overflow = rx_push & rx_full;
      if (flag_seen && !rx_flush)
         d.rx_on = 1'b1;
      if (d.overflow || rx_flush)
         d.rx_on = 1'b0;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         q         <= '0;
         q.sync_m  <= hdlc_status_pkg::SYNC_RESET;
         q.sync_s  <= hdlc_status_pkg::SYNC_RESET;
         q.sync_p  <= hdlc_status_pkg::SYNC_RESET;
         q.control <= hdlc_status_pkg::CONTROL2_RESET;
         q.oe_n    <= 1'b1;
      end
      else
         q <= d;
   end

   // outputs from registers
   assign host_data_out        = q.rdata;
   assign host_data_oe_n       = q.oe_n;
   assign tx_byte              = q.tx_byte;
   assign tx_byte_tag          = q.tx_tag;
   assign tx_append_check      = q.append_check;
   assign tx_underrun_flag     = q.underrun;
   assign tx_count             = q.count;
   assign address_match        = q.addr_match;
   assign interrupt_bit2_event = q.bit2_event;
   assign rx_abort_event       = q.abort;
   assign rx_overflow_flag     = q.overflow;
   assign rx_enabled           = q.rx_on;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   int_raise_a: assert property (unmasked_event |=> q.int_raised)
      else $error("interrupt bit not raised");

   bit2_select_a: assert property (
      (tx_pop && tx_empty && q.control[hdlc_status_pkg::CTL_INT_SELECT])
      |=> (interrupt_bit2_event && tx_underrun_flag))
      else $error("underrun not routed to bit two");

   check_off_a: assert property (tx_pop && !tx_empty
      && q.control[hdlc_status_pkg::CTL_CHECK_SUPPRESS] |=> !tx_append_check)
      else $error("check appended while suppressed");

   short_addr_a: assert property (
      (rx_address_valid && !rx_address_byte[0]
       && q.control[hdlc_status_pkg::CTL_SHORT_ADDRESS]) |=> !address_match)
      else $error("short address matched with bit zero low");

   rx_flush_a: assert property (rx_flush |=> !rx_enabled)
      else $error("receiver on during flush");

   tx_flush_end_a: assert property (
      tx_push |=> !q.control[hdlc_status_pkg::CTL_TX_FLUSH])
      else $error("transmit flush not cleared by write");

   overflow_stop_a: assert property (
      (rx_push && rx_full) |=> (rx_overflow_flag && !rx_enabled))
      else $error("overflow not flagged or receiver still on");

   status_ro_a: assert property (
      (wr_edge && hit(q, hdlc_status_pkg::ADDR_STATUS) && !tx_push) |=> $stable(q.control))
      else $error("status write changed a register");

endmodule

//--- test/tb.sv
// bench for the hdlc status and second control block
// assumes the package and design files compile first; 40 MHz clock
`timescale 1ns/1ps
module tb;
   // ==========================================
   // design signals and bench state
   logic       clk, reset_n, host_cs_n, host_rd_n, host_wr_n, receive_line_clock;
   logic       rx_line_data, rx_write_valid, packet_end_tag, frame_abort_flag, tx_fetch;
   logic       tx_count_load, rx_address_valid, unmasked_event, host_data_oe_n;
   logic       tx_append_check, tx_underrun_flag, address_match, interrupt_bit2_event;
   logic       rx_abort_event, rx_overflow_flag, rx_enabled, seen;
   logic [4:0] host_addr;
   logic [7:0] host_data_in, host_data_out, rx_write_data, rx_threshold, tx_threshold;
   logic [7:0] tx_full_level, tx_byte, tx_count_value, tx_count, rx_address_byte, own_address, x;
   logic [1:0] rx_write_tag, tx_byte_tag;
   logic [15:0] exp_q[$], nt;
   logic [31:0] seed = 32'h47;
   int         errors = 0, checked = 0, oe_cnt = 0;

   hdlc_status_control DUT (.clk, .reset_n, .host_addr, .host_data_in, .host_data_out,
      .host_data_oe_n, .host_cs_n, .host_rd_n, .host_wr_n, .receive_line_clock,
      .rx_line_data, .rx_write_valid, .rx_write_data, .rx_write_tag, .rx_threshold,
      .tx_threshold, .tx_full_level, .packet_end_tag, .frame_abort_flag, .tx_fetch,
      .tx_byte, .tx_byte_tag, .tx_append_check, .tx_underrun_flag, .tx_count_load,
      .tx_count_value, .tx_count, .rx_address_valid, .rx_address_byte, .own_address,
      .address_match, .unmasked_event, .interrupt_bit2_event, .rx_abort_event,
      .rx_overflow_flag, .rx_enabled);

   // ==========================================
   // helpers
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task chk(input logic [7:0] a, e, m);
      checked++;
      if ((a & m) !== (e & m))
      begin
         errors++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, a, e);
      end
   endtask
   task test_done;
      errors += exp_q.size();  // unanswered read notes count as misses
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // host access: address settles, strobe low, then all released
   task acc(input logic r, input logic [4:0] a, input logic [7:0] d);
      host_addr <= a;
      host_data_in <= d;
      host_cs_n <= 1'b0;
      repeat (4) @(posedge clk);
      if (r) host_rd_n <= 1'b0;
      else host_wr_n <= 1'b0;
      repeat (8) @(posedge clk);
      {host_cs_n, host_rd_n, host_wr_n} <= 3'h7;
      repeat (4) @(posedge clk);
   endtask
   task rd(input logic [4:0] a, input logic [7:0] e, m);
      exp_q.push_back({m, e});
      acc(1'b1, a, 8'h00);
   endtask
   // one-cycle pulse: 0 byte push, 1 fetch, 2 address, 3 event, 4 count load
   task pu(input int k);
      {tx_count_load, unmasked_event, rx_address_valid, tx_fetch, rx_write_valid} <= 5'h01 << k;
      @(posedge clk);
      {tx_count_load, unmasked_event, rx_address_valid, tx_fetch, rx_write_valid} <= 5'h00;
      repeat (3) @(posedge clk);
   endtask
   task automatic cat(ref logic p, input logic e);
      seen = 1'b0;
      repeat (5) @(posedge clk) seen |= p;
      chk({7'h00, seen}, {7'h00, e}, 8'h01);
   endtask
   task lb(input logic b);
      rx_line_data <= b;
      @(posedge clk) receive_line_clock <= 1'b1;
      repeat (4) @(posedge clk);
      receive_line_clock <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task push(input logic [7:0] d, input logic [1:0] t);
      rx_write_data <= d;
      rx_write_tag <= t;
      pu(0);
   endtask
   task flag;
      for (int i = 0; i < 8; i++) lb(hdlc_status_pkg::FLAG_PATTERN[i]);
   endtask

   // ==========================================
   // clock, watchdog and read-answer watcher
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      repeat (8000) @(posedge clk);
      errors++;
      test_done;
   end
   // compares each read answer with the oldest note
   always @(posedge clk)
   begin
      oe_cnt <= host_data_oe_n ? 0 : oe_cnt + 1;
      if (oe_cnt == 3 && exp_q.size() > 0)
      begin
         nt = exp_q.pop_front();
         chk(host_data_out, nt[7:0], nt[15:8]);
      end
   end

   // ==========================================
   // main sequence
   initial
   begin
      {receive_line_clock, rx_write_valid, packet_end_tag, frame_abort_flag, tx_fetch,
         tx_count_load, rx_address_valid, unmasked_event, host_addr, host_data_in,
         rx_write_data, rx_write_tag, tx_count_value, rx_address_byte, reset_n} = '0;
      {host_cs_n, host_rd_n, host_wr_n, rx_line_data} = 4'hf;
      {rx_threshold, tx_threshold, tx_full_level, own_address} = 32'h020102a4;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      rd(5'h14, 8'h48, 8'hcf);
      acc(1'b0, 5'h14, 8'hff);
      rd(5'h14, 8'h48, 8'hcf);
      rd(5'h15, 8'h00, 8'hff);
      x = xs() & 8'hf0;
      acc(1'b0, 5'h15, x);
      rd(5'h15, x, 8'hff);
      rd(5'h1f, 8'h00, 8'hff);
      $display("register test done");
      acc(1'b0, 5'h15, 8'h00);
      flag;
      chk({7'h00, rx_enabled}, 8'h01, 8'h01);
      x = xs();
      push(x, 2'h1);
      rd(5'h14, 8'h19, 8'hff);
      push(xs(), 2'h2);
      rd(5'h14, 8'h1b, 8'hff);
      rd(5'h12, x, 8'hff);
      rd(5'h14, 8'h29, 8'hff);
      acc(1'b0, 5'h15, 8'h02);
      rd(5'h14, 8'h00, 8'h03);
      chk({7'h00, rx_enabled}, 8'h00, 8'h01);
      acc(1'b0, 5'h15, 8'h00);
      flag;
      repeat (128) push(xs(), 2'h0);
      rd(5'h14, 8'h02, 8'h03);
      rx_write_valid <= 1'b1;
      @(posedge clk) rx_write_valid <= 1'b0;
      cat(rx_overflow_flag, 1'b1);
      chk({7'h00, rx_enabled}, 8'h00, 8'h01);
      $display("receive test done");
      acc(1'b0, 5'h15, 8'h80);
      x = xs();
      packet_end_tag <= 1'b1;
      acc(1'b0, 5'h12, x);
      packet_end_tag <= 1'b0;
      rd(5'h14, 8'h04, 8'h0c);
      pu(1);
      chk(tx_byte, x, 8'hff);
      chk({4'h0, tx_byte_tag, 1'b0, tx_append_check}, 8'h09, 8'h0d);
      rd(5'h14, 8'h08, 8'h0c);
      tx_fetch <= 1'b1;
      @(posedge clk) tx_fetch <= 1'b0;
      cat(tx_underrun_flag, 1'b1);
      tx_fetch <= 1'b1;
      @(posedge clk) tx_fetch <= 1'b0;
      cat(interrupt_bit2_event, 1'b1);
      acc(1'b0, 5'h15, 8'h20);
      tx_fetch <= 1'b1;
      @(posedge clk) tx_fetch <= 1'b0;
      cat(interrupt_bit2_event, 1'b0);
      packet_end_tag <= 1'b1;
      acc(1'b0, 5'h12, xs());
      packet_end_tag <= 1'b0;
      pu(1);
      chk({7'h00, tx_append_check}, 8'h00, 8'h01);
      acc(1'b0, 5'h12, xs());
      acc(1'b0, 5'h15, 8'h01);
      rd(5'h14, 8'h08, 8'h0c);
      acc(1'b0, 5'h12, xs());
      rd(5'h15, 8'h00, 8'hff);
      rd(5'h14, 8'h04, 8'h0c);
      acc(1'b0, 5'h15, 8'h40);
      repeat (2) acc(1'b0, 5'h12, xs());
      tx_count_value <= 8'h03;
      pu(4);
      repeat (3) pu(1);
      chk(tx_count, 8'h02, 8'hff);
      $display("transmit test done");
      acc(1'b0, 5'h15, 8'h10);
      rx_address_byte <= own_address | 8'h01;
      pu(2);
      chk({7'h00, address_match}, 8'h01, 8'h01);
      rx_address_byte <= own_address & 8'hfe;
      pu(2);
      chk({7'h00, address_match}, 8'h00, 8'h01);
      pu(3);
      rd(5'h14, 8'h80, 8'h80);
      rd(5'h17, 8'h00, 8'h00);
      rd(5'h14, 8'h00, 8'h80);
      flag;
      repeat (20) lb(1'b0);
      repeat (6) lb(1'b1);
      fork
         lb(1'b1);
         begin
            repeat (2) @(posedge clk);
            cat(rx_abort_event, 1'b1);
         end
      join
      lb(1'b0);
      repeat (15) lb(1'b1);
      rd(5'h14, 8'h40, 8'h40);
      $display("interrupt and line test done");
      test_done;
   end
endmodule
